// >>> tb_top.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: ps 0 gives a time-out after 32 source edges
// Notes:   oscillators free-run, unrelated in phase to clk
`timescale 1ns/1ps
module tb_top
   import watchdog_pkg::*;
;
   // ==========================================
   // stimulus and observed signals
   localparam logic [8:0] S_CLR = 9'h001, S_RD = 9'h002, S_W0 = 9'h004, S_W1 = 9'h008;
   localparam logic [8:0] S_WFS = 9'h010, S_RFC = 9'h020, S_SEN = 9'h040, S_SEX = 9'h080;
   localparam logic [8:0] S_OF  = 9'h100;
   logic                clk = 1'b0, rst = 1'b1, por = 1'b1;
   logic                lf = 1'b0, mf = 1'b0, sec = 1'b0;
   logic [1:0]          en_cfg = 2'h0;
   logic [2:0]          src_cfg = 3'h0, win_cfg = 3'h7, src_wd = 3'h0, win_wd = 3'h7;
   logic [8:0]          stb = 9'h000;
   logic [4:0]          ps_wd = 5'h00;
   logic                sw_wd = 1'b0, in_sleep = 1'b0, ost_run = 1'b0, hit;
   logic                system_reset, wake, window_violation_flag_n, watchdog_reset_flag;
   logic                timeout_status_bit, powerdown_status_bit, software_watchdog_on, armed;
   logic [4:0]          prescale_select;
   logic [2:0]          clock_source_select, window_select;
   logic [CNT_WIDTH-1:0] counter_value;
   logic [PS_WIDTH-1:0] prescale_count;
   int                  mismatches = 0, total_checks = 0;
   // rows: enable[7:6] swon[5] sleep[4] source[3:1] counting[0]
   logic [7:0]          rows [11] = '{8'h20, 8'h40, 8'h61, 8'h71, 8'h81, 8'h90, 8'hd1,
                                      8'hc3, 8'hc5, 8'hc6, 8'h14};

   always #2.5 clk = ~clk;
   always #20.3 lf = ~lf;
   always #25.7 mf = ~mf;
   always #30.9 sec = ~sec;

   windowed_watchdog_timer i_dut (
      .clk(clk), .rst(rst), .por(por),
      .low_freq_internal_osc(lf), .mid_freq_internal_osc(mf), .secondary_osc(sec),
      .watchdog_enable_config(en_cfg), .clock_source_config(src_cfg),
      .window_size_config(win_cfg), .watchdog_clear_instruction(stb[0]),
      .control_0_read(stb[1]), .control_0_write(stb[2]), .prescale_select_wdata(ps_wd),
      .software_watchdog_on_wdata(sw_wd), .control_1_write(stb[3]),
      .clock_source_select_wdata(src_wd), .window_select_wdata(win_wd),
      .window_flag_set(stb[4]), .reset_flag_clear(stb[5]), .in_sleep(in_sleep),
      .sleep_enter(stb[6]), .sleep_exit(stb[7]), .osc_startup_timer_running(ost_run),
      .osc_fail(stb[8]), .system_reset(system_reset), .wake(wake),
      .window_violation_flag_n(window_violation_flag_n),
      .watchdog_reset_flag(watchdog_reset_flag), .timeout_status_bit(timeout_status_bit),
      .powerdown_status_bit(powerdown_status_bit), .prescale_select(prescale_select),
      .software_watchdog_on(software_watchdog_on), .clock_source_select(clock_source_select),
      .window_select(window_select), .armed(armed), .counter_value(counter_value),
      .prescale_count(prescale_count)
   );

   // ==========================================
   // shared tasks
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pulse(input logic [8:0] m);
      @(posedge clk);
      stb <= m;
      @(posedge clk);
      stb <= 9'h000;
   endtask

   // writing control 0 also zeroes the counter
   task automatic setup(input logic [1:0] en, input logic [2:0] src, input logic [2:0] win,
                        input logic [4:0] ps, input logic sw, input logic sl);
      @(posedge clk);
      en_cfg <= en;
      src_cfg <= src;
      win_cfg <= win;
      ps_wd <= ps;
      sw_wd <= sw;
      in_sleep <= sl;
      pulse(S_W0);
   endtask

   // bounded wait: 0 reset, 1 wake, 2 window open, 3 counting
   task automatic wait_evt(input int sel, input int lim, output logic h);
      int n;
      h = 1'b0;
      for (n = 0; n < lim && !h; n++) begin
         @(negedge clk);
         case (sel)
            0: h = (system_reset === 1'b1);
            1: h = (wake === 1'b1);
            2: h = ((counter_value >= 5'h1c) === 1'b1);
            default: h = ((counter_value >= 5'h04) === 1'b1);
         endcase
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================
   // watchdog against a hung design
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end

   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      foreach (rows[i]) begin
         setup(rows[i][7:6], rows[i][3:1], 3'h7, 5'h00, rows[i][5], rows[i][4]);
         repeat (60) @(negedge clk);
         check(counter_value != 5'h00, rows[i][0]);
      end
      // runtime source and control write clearing
      setup(EN_ALWAYS, SRC_RUNTIME, 3'h7, 5'h00, 1'b1, 1'b0);
      src_wd <= SRC_MF;
      pulse(S_W1);
      @(negedge clk);
      check(clock_source_select, SRC_MF);
      wait_evt(3, 100, hit);
      check(hit, 1'b1);
      @(posedge clk);
      src_wd <= 3'h5;
      pulse(S_W1);
      @(negedge clk);
      check(counter_value, 5'h00);
      repeat (60) @(negedge clk);
      check(counter_value, 5'h00);
      // runtime window only honoured under config 111
      @(posedge clk);
      win_wd <= 3'h3;
      pulse(S_W1);
      @(negedge clk);
      check(window_select, 3'h3);
      @(posedge clk);
      win_cfg <= 3'h0;
      win_wd <= 3'h7;
      pulse(S_W1);
      @(negedge clk);
      check(window_select, 3'h0);
      @(posedge clk);
      win_cfg <= 3'h7;
      @(negedge clk);
      check(window_select, 3'h3);
      pulse(S_W1);
      // reserved prescale code acts as 1:32
      setup(EN_ALWAYS, SRC_LF, 3'h7, 5'h13, 1'b1, 1'b0);
      wait_evt(0, 320, hit);
      check(hit, 1'b1);
      check(timeout_status_bit, 1'b0);
      check(watchdog_reset_flag, 1'b1);
      pulse(S_RFC);
      @(negedge clk);
      check(watchdog_reset_flag, 1'b0);
      pulse(S_CLR);
      wait_evt(0, 4, hit);
      check(hit, 1'b0);
      check(timeout_status_bit, 1'b1);
      // 12.5 percent window: unarmed, early and valid service
      setup(EN_ALWAYS, SRC_LF, 3'h0, 5'h00, 1'b1, 1'b0);
      wait_evt(2, 400, hit);
      pulse(S_CLR);
      wait_evt(0, 4, hit);
      check(hit, 1'b1);
      check(window_violation_flag_n, 1'b0);
      pulse(S_W0);
      pulse(S_RD);
      @(negedge clk);
      check(armed, 1'b1);
      pulse(S_CLR);
      wait_evt(0, 4, hit);
      check(hit, 1'b1);
      pulse(S_W0);
      wait_evt(2, 400, hit);
      pulse(S_RD);
      pulse(S_CLR);
      wait_evt(0, 4, hit);
      check(hit, 1'b0);
      check(armed, 1'b0);
      check(counter_value < 5'h02, 1'b1);
      // sleep entry, sleep time-out, sleep exit
      setup(EN_ALWAYS, SRC_LF, 3'h7, 5'h00, 1'b1, 1'b0);
      wait_evt(3, 100, hit);
      @(posedge clk);
      in_sleep <= 1'b1;
      pulse(S_SEN);
      @(negedge clk);
      check(counter_value, 5'h00);
      check(powerdown_status_bit, 1'b0);
      wait_evt(1, 400, hit);
      check(hit, 1'b1);
      check(system_reset, 1'b0);
      check(timeout_status_bit, 1'b0);
      check(watchdog_reset_flag, 1'b1);
      wait_evt(3, 100, hit);
      @(posedge clk);
      in_sleep <= 1'b0;
      pulse(S_SEX);
      @(negedge clk);
      check(counter_value, 5'h00);
      // start-up timer hold, oscillator failure, disable
      @(posedge clk);
      ost_run <= 1'b1;
      repeat (80) @(negedge clk);
      check(counter_value, 5'h00);
      check(prescale_count, 18'h00000);
      @(posedge clk);
      ost_run <= 1'b0;
      wait_evt(3, 100, hit);
      check(hit, 1'b1);
      pulse(S_OF);
      @(negedge clk);
      check(counter_value, 5'h00);
      check(prescale_count, 18'h00000);
      wait_evt(3, 100, hit);
      @(posedge clk);
      en_cfg <= EN_OFF;
      repeat (3) @(negedge clk);
      check(counter_value, 5'h00);
      // plain reset keeps flags, power-on reset restores them
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(prescale_select, PS_RESET);
      check(software_watchdog_on, SWON_RESET);
      check(window_violation_flag_n, 1'b0);
      pulse(S_WFS);
      @(negedge clk);
      check(window_violation_flag_n, 1'b1);
      @(posedge clk);
      rst <= 1'b1;
      por <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      @(negedge clk);
      check(watchdog_reset_flag, 1'b0);
      check(powerdown_status_bit, 1'b1);
      close_out();
   end
endmodule

// >>> watchdog_pkg.sv
// Purpose: shared constants of the windowed watchdog
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes:   codes follow the configuration and control fields
package watchdog_pkg;
   // ==========================================
   // enable modes
   localparam logic [1:0] EN_OFF    = 2'h0;
   localparam logic [1:0] EN_SW     = 2'h1;
   localparam logic [1:0] EN_AWAKE  = 2'h2;
   localparam logic [1:0] EN_ALWAYS = 2'h3;
   // ==========================================
   // time base sources
   localparam logic [2:0] SRC_LF      = 3'h0;
   localparam logic [2:0] SRC_MF      = 3'h1;
   localparam logic [2:0] SRC_SEC     = 3'h2;
   localparam logic [2:0] SRC_RUNTIME = 3'h7;
   // ==========================================
   // window and prescale
   localparam logic [2:0] WIN_FULL    = 3'h7;
   localparam logic [4:0] PS_RESET    = 5'h0b;
   localparam logic [4:0] PS_MAX      = 5'h12;
   localparam int         PS_WIDTH    = 18;
   localparam int         CNT_WIDTH   = 5;
   localparam logic [4:0] CNT_TOP     = 5'h1f;
   localparam logic [4:0] CNT_ZERO    = 5'h00;
   localparam logic       SWON_RESET  = 1'b0;
endpackage

// >>> watchdog_prescaler.sv
// Purpose: time base pick and 18-bit prescale counter
// Assumes: oscillator inputs are slow and asynchronous to clk
// Notes:   tap pulses once per 2^n source edges
`timescale 1ns/1ps
module watchdog_prescaler
   import watchdog_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                clear,
   input  wire logic                low_freq_internal_osc,
   input  wire logic                mid_freq_internal_osc,
   input  wire logic                secondary_osc,
   input  wire logic [2:0]          source,
   input  wire logic [4:0]          prescale,
   output logic                     tap,
   output logic [PS_WIDTH-1:0]      count
);
   typedef struct packed {
      logic [2:0]          sync1;
      logic [2:0]          sync2;
      logic [2:0]          prev;
      logic [PS_WIDTH-1:0] count;
      logic                tap;
   } pre_state_t;

   pre_state_t          q;
   pre_state_t          d;
   logic [2:0]          edges;
   logic                tick;
   logic [4:0]          ps_eff;
   logic [PS_WIDTH:0]   mask_wide;
   logic [PS_WIDTH-1:0] mask;

   // ==========================================
   // next state
   always_comb begin
      d       = q;
      d.sync1 = {secondary_osc, mid_freq_internal_osc, low_freq_internal_osc};
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      edges   = q.sync2 & ~q.prev;
      unique case (source)
         SRC_LF:  tick = edges[0];
         SRC_MF:  tick = edges[1];
         SRC_SEC: tick = edges[2];
         default: tick = 1'b0;
      endcase
      ps_eff    = (prescale > PS_MAX) ? 5'h00 : prescale;
      mask_wide = ({{PS_WIDTH{1'b0}}, 1'b1} << ps_eff) - {{PS_WIDTH{1'b0}}, 1'b1};
      mask      = mask_wide[PS_WIDTH-1:0];
      d.tap     = 1'b0;
      if (clear) begin
         d.count = '0;
      end else if (tick) begin
         d.tap   = ((q.count & mask) == mask);
         d.count = q.count + {{(PS_WIDTH-1){1'b0}}, 1'b1};
      end
      if (rst) begin
         d = '0;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign tap   = q.tap;
   assign count = q.count;

   // ==========================================
   // checks
   // minimum interval
   property p_reserved_min;
      @(posedge clk) disable iff (rst)
      (prescale > PS_MAX && tick && !clear) |=> tap;
   endproperty
   a_reserved_min: assert property (p_reserved_min)
      else $error("reserved prescale code did not tap every edge");

   property p_source_count;
      @(posedge clk) disable iff (rst)
      (source == SRC_LF && edges[0] && !clear) |=> count == $past(count) + 18'h00001;
   endproperty
   a_source_count: assert property (p_source_count)
      else $error("prescaler missed an edge of the selected source");
endmodule

// >>> windowed_watchdog_timer.sv
// Purpose: windowed watchdog timer with sleep wake-up
// Assumes: control strobes are one-cycle pulses on clk;
//          por is raised only together with rst
// Notes:   time-out is 2^(5+prescale) source edges
//
// Behaviour
// - reset when not serviced before time-out
// - count from selectable slow time base
// - source codes 000 lf, 001 mf, 010 secondary
// - mode 11 active always, sleep too
// - mode 10 active except in sleep
// - mode 01 follows software enable bit
// - mode 00 always disabled
// - time-out selectable, two seconds after reset
// - divide 1:32 doubling, reserved codes minimum
// - clear outside open window is violation
// - runtime window used only when config 111
// - open window 12.5 to 100 percent
// - violation clears active-low flag, por sets
// - counter cleared on listed system events
// - control register writes clear counter
// - windowed clear needs arming read first
// - clear on sleep entry and exit
// - held zero while startup timer runs
// - sleep time-out wakes instead of reset
// - osc failure clears, divider change clears via control 0 write
`timescale 1ns/1ps
module windowed_watchdog_timer
   import watchdog_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                por,
   input  wire logic                low_freq_internal_osc,
   input  wire logic                mid_freq_internal_osc,
   input  wire logic                secondary_osc,
   input  wire logic [1:0]          watchdog_enable_config,
   input  wire logic [2:0]          clock_source_config,
   input  wire logic [2:0]          window_size_config,
   input  wire logic                watchdog_clear_instruction,
   input  wire logic                control_0_read,
   input  wire logic                control_0_write,
   input  wire logic [4:0]          prescale_select_wdata,
   input  wire logic                software_watchdog_on_wdata,
   input  wire logic                control_1_write,
   input  wire logic [2:0]          clock_source_select_wdata,
   input  wire logic [2:0]          window_select_wdata,
   input  wire logic                window_flag_set,
   input  wire logic                reset_flag_clear,
   input  wire logic                in_sleep,
   input  wire logic                sleep_enter,
   input  wire logic                sleep_exit,
   input  wire logic                osc_startup_timer_running,
   input  wire logic                osc_fail,
   output logic                     system_reset,
   output logic                     wake,
   output logic                     window_violation_flag_n,
   output logic                     watchdog_reset_flag,
   output logic                     timeout_status_bit,
   output logic                     powerdown_status_bit,
   output logic [4:0]               prescale_select,
   output logic                     software_watchdog_on,
   output logic [2:0]               clock_source_select,
   output logic [2:0]               window_select,
   output logic                     armed,
   output logic [CNT_WIDTH-1:0]     counter_value,
   output logic [PS_WIDTH-1:0]      prescale_count
);
   typedef struct packed {
      logic [4:0]           prescale_sel;
      logic                 swon;
      logic [2:0]           src_sel;
      logic [2:0]           win_sel;
      logic [CNT_WIDTH-1:0] count;
      logic                 armed;
      logic                 sys_reset;
      logic                 wake;
      logic                 win_flag_n;
      logic                 reset_flag;
      logic                 timeout_bit;
      logic                 powerdown_bit;
   } wd_state_t;

   wd_state_t  q;
   wd_state_t  d;
   logic       tap;
   logic       active;
   logic [2:0] src_eff;
   logic [2:0] win_eff;
   logic       windowed;
   logic       window_open;
   logic       hold_clear;
   logic       clr_seen;
   logic       violation;
   logic       valid_clear;
   logic       timeout_ev;
   logic       counter_clear;

   // ==========================================
   // time base
   watchdog_prescaler u_prescaler (
      .clk                   (clk),
      .rst                   (rst || por),
      .clear                 (counter_clear),
      .low_freq_internal_osc (low_freq_internal_osc),
      .mid_freq_internal_osc (mid_freq_internal_osc),
      .secondary_osc         (secondary_osc),
      .source                (src_eff),
      .prescale              (q.prescale_sel),
      .tap                   (tap),
      .count                 (prescale_count)
   );

   // ==========================================
   // mode decode
   always_comb begin
      unique case (watchdog_enable_config)
         EN_ALWAYS: active = 1'b1;
         EN_AWAKE:  active = !in_sleep;
         EN_SW:     active = q.swon;
         EN_OFF:    active = 1'b0;
      endcase
   end

   assign src_eff     = (clock_source_config == SRC_RUNTIME) ? q.src_sel : clock_source_config;
   // runtime window only when config allows
   assign win_eff     = (window_size_config == WIN_FULL) ? q.win_sel : window_size_config;
   assign windowed    = (win_eff != WIN_FULL);
   // closed part is (7 - code) eighths of period
   assign window_open = (q.count[4:2] >= (WIN_FULL - win_eff));

   // ==========================================
   // clear sources
   // clearing events
   // divider changes arrive by control 0 write, which clears the counter
   assign hold_clear  = !active || sleep_enter || sleep_exit || osc_startup_timer_running
                        || osc_fail || control_0_write || control_1_write;
   assign clr_seen    = watchdog_clear_instruction && active;
   assign violation   = clr_seen && windowed && (!q.armed || !window_open);
   assign valid_clear = clr_seen && !violation;
   // overflow together with tap; a service in the same cycle wins
   assign timeout_ev  = tap && (q.count == CNT_TOP) && !hold_clear && !clr_seen;
   assign counter_clear = hold_clear || valid_clear || violation || timeout_ev;

   // ==========================================
   // next state
   always_comb begin
      d           = q;
      d.sys_reset = 1'b0;
      d.wake      = 1'b0;
      if (control_0_write) begin
         d.prescale_sel = prescale_select_wdata;
         d.swon         = software_watchdog_on_wdata;
      end
      // runtime fields are read-only unless configuration hands them over
      if (control_1_write && clock_source_config == SRC_RUNTIME) begin
         d.src_sel = clock_source_select_wdata;
      end
      if (control_1_write && window_size_config == WIN_FULL) begin
         d.win_sel = window_select_wdata;
      end
      if (counter_clear) begin
         d.count = CNT_ZERO;
      end else if (tap) begin
         d.count = q.count + 5'h01;
      end
      if (control_0_read) begin
         d.armed = 1'b1;
      end else if (counter_clear) begin
         d.armed = 1'b0;
      end
      if (watchdog_clear_instruction) begin
         d.timeout_bit   = 1'b1;
         d.powerdown_bit = 1'b1;
      end
      if (sleep_enter) begin
         d.timeout_bit   = 1'b1;
         d.powerdown_bit = 1'b0;
      end
      // firmware strobes first so hardware events win
      if (window_flag_set) begin
         d.win_flag_n = 1'b1;
      end
      if (reset_flag_clear) begin
         d.reset_flag = 1'b0;
      end
      // time-out: reset when awake, wake when asleep
      if (timeout_ev) begin
         d.reset_flag  = 1'b1;
         d.timeout_bit = 1'b0;
         if (in_sleep) begin
            d.wake          = 1'b1;
            d.powerdown_bit = 1'b0;
         end else begin
            d.sys_reset = 1'b1;
         end
      end
      if (violation) begin
         d.sys_reset  = 1'b1;
         d.win_flag_n = 1'b0;
         d.reset_flag = 1'b1;
      end
      // any reset; cause flags survive a plain rst for firmware
      if (rst || por) begin
         d.prescale_sel = PS_RESET;
         d.swon         = SWON_RESET;
         d.src_sel      = SRC_LF;
         d.win_sel      = window_size_config;
         d.count        = CNT_ZERO;
         d.armed        = 1'b0;
         d.sys_reset    = 1'b0;
         d.wake         = 1'b0;
      end
      if (por) begin
         d.win_flag_n    = 1'b1;
         d.reset_flag    = 1'b0;
         d.timeout_bit   = 1'b1;
         d.powerdown_bit = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   // ==========================================
   // outputs
   assign system_reset            = q.sys_reset;
   assign wake                    = q.wake;
   assign window_violation_flag_n = q.win_flag_n;
   assign watchdog_reset_flag     = q.reset_flag;
   assign timeout_status_bit      = q.timeout_bit;
   assign powerdown_status_bit    = q.powerdown_bit;
   assign prescale_select         = q.prescale_sel;
   assign software_watchdog_on    = q.swon;
   assign clock_source_select     = src_eff;
   assign window_select           = win_eff;
   assign armed                   = q.armed;
   assign counter_value           = q.count;

   // ==========================================
   // checks
   // awake time-out resets
   property p_timeout_reset;
      @(posedge clk) disable iff (rst || por)
      (timeout_ev && !in_sleep) |=> (system_reset && !timeout_status_bit && watchdog_reset_flag);
   endproperty
   a_timeout_reset: assert property (p_timeout_reset)
      else $error("time-out did not reset");

   property p_sleep_wake;
      @(posedge clk) disable iff (rst || por)
      (timeout_ev && in_sleep) |=> (wake && !system_reset && !powerdown_status_bit);
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("sleep time-out did not wake cleanly");

   property p_always_counts;
      @(posedge clk) disable iff (rst || por)
      (watchdog_enable_config == EN_ALWAYS && in_sleep && tap && q.count != CNT_TOP
       && !hold_clear && !watchdog_clear_instruction)
      |=> counter_value == $past(counter_value) + 5'h01;
   endproperty
   a_always_counts: assert property (p_always_counts)
      else $error("always-on watchdog stopped in sleep");

   property p_awake_only;
      @(posedge clk) disable iff (rst || por)
      (watchdog_enable_config == EN_AWAKE && in_sleep) |=> counter_value == CNT_ZERO;
   endproperty
   a_awake_only: assert property (p_awake_only)
      else $error("awake-only watchdog counted in sleep");

   property p_off_zero;
      @(posedge clk) disable iff (rst || por)
      (watchdog_enable_config == EN_OFF || (watchdog_enable_config == EN_SW && !q.swon))
      |=> (counter_value == CNT_ZERO && !system_reset);
   endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("disabled watchdog ran");

   property p_closed_window;
      @(posedge clk) disable iff (rst || por)
      (clr_seen && windowed && q.armed && !window_open)
      |=> (system_reset && !window_violation_flag_n);
   endproperty
   a_closed_window: assert property (p_closed_window)
      else $error("clear in closed window accepted");

   property p_unarmed;
      @(posedge clk) disable iff (rst || por)
      (clr_seen && windowed && !q.armed) |=> (system_reset && counter_value == CNT_ZERO);
   endproperty
   a_unarmed: assert property (p_unarmed)
      else $error("unarmed clear accepted");

   property p_full_window;
      @(posedge clk) disable iff (rst || por)
      (clr_seen && win_eff == WIN_FULL && !timeout_ev) |=> !system_reset;
   endproperty
   a_full_window: assert property (p_full_window)
      else $error("clear with full window caused reset");

   property p_write_clears;
      @(posedge clk) disable iff (rst || por)
      (control_0_write || control_1_write) |=> counter_value == CNT_ZERO;
   endproperty
   a_write_clears: assert property (p_write_clears)
      else $error("control write left counter running");

   property p_startup_hold;
      @(posedge clk) disable iff (rst || por)
      osc_startup_timer_running [*2] |-> counter_value == CNT_ZERO;
   endproperty
   a_startup_hold: assert property (p_startup_hold)
      else $error("counter moved during oscillator start-up");

   property p_rearm;
      @(posedge clk) disable iff (rst || por)
      (valid_clear && !control_0_read) |=> (!armed && counter_value == CNT_ZERO);
   endproperty
   a_rearm: assert property (p_rearm)
      else $error("arming survived a service");
endmodule
